/* logic/eio_consts.vh */
// Constants for the eight-bit I/O port: register indexes, reset values, power modes
`ifndef EIO_CONSTS_VH
`define EIO_CONSTS_VH

// Register indexes; byte address on APB is four times the index
`define EIO_IDX_LATCH      16'hFFD8
`define EIO_IDX_DIRECTION  16'hFFE8
`define EIO_IDX_PULLUP     16'hFFEF

// APB address width needed to reach the highest index
`define EIO_ADDR_W         18

// Reset values
`define EIO_LATCH_RST      8'h00
`define EIO_DIRECTION_RST  8'h00
`define EIO_PULLUP_RST     8'h00

// Read value of the write-only direction register
`define EIO_DIRECTION_RD   8'hFF

// Power mode codes on pwr_mode
`define EIO_MODE_W         3
`define EIO_MODE_ACTIVE    3'h0
`define EIO_MODE_SUBACTIVE 3'h1
`define EIO_MODE_SLEEP     3'h2
`define EIO_MODE_SUBSLEEP  3'h3
`define EIO_MODE_WATCH     3'h4
`define EIO_MODE_STANDBY   3'h5

// Synchroniser depth
`define EIO_SYNC_STAGES    2

`endif

/* logic/eio_port.v */
// Eight-bit general-purpose I/O port with APB register access and pull-ups
//
// Implementation choice: the APB interface to the registers.
`timescale 1ns/10ps
`include "eio_consts.vh"

// Contract
// - Eight-bit output latch, software read/write, drives pins set as outputs.
// - Direction bit 1: data read returns the latched bit, not the pin.
// - Direction bit 0: data read returns the sampled pin level.
// - Direction bit 1 makes the pin output, 0 makes it input.
// - Direction register is write-only; reading it returns all ones.
// - Reset clears latch, direction and pull-up control; all pins inputs.
// - Pull-up on when direction bit is 0 and pull-up bit is 1.
// - Pull-up off when pull-up bit is 0 or direction bit is 1.
// - After reset every pull-up stays off until software enables it.
// - Pin 7 always feeds its interrupt input from the pin level.
// - Pin 6 feeds interrupt and timer event inputs from the pin level.
// - High-z in reset and standby, hold in sleep, subsleep and watch, live otherwise.
// - In standby an enabled pull-up keeps the pin high.
module eio_port
#(
   parameter ADDR_W = `EIO_ADDR_W,
   parameter NPINS  = 8
)
(
   input  wire              core_clk,                     // System clock, 25 MHz
   input  wire              rst_b,                        // Asynchronous reset, active low
   input  wire              clk_en,                       // Clock enable, freezes all state when low
   input  wire              psel,                         // APB select
   input  wire              penable,                      // APB access phase
   input  wire              pwrite,                       // APB direction, 1 = write
   input  wire [ADDR_W-1:0] paddr,                        // APB byte address
   input  wire [31:0]       pwdata,                       // APB write data
   input  wire [3:0]        pstrb,                        // APB byte strobes
   output wire [31:0]       prdata,                       // APB read data
   output wire              pready,                       // APB ready
   output wire              pslverr,                      // APB error, unmapped address
   input  wire [`EIO_MODE_W-1:0] pwr_mode,                // Current power mode code
   input  wire [NPINS-1:0]  pin_in,                       // Pad input levels, asynchronous
   output wire [NPINS-1:0]  pin_out,                      // Pad output data
   output wire [NPINS-1:0]  pin_oe,                       // Pad output enable, high drives
   output wire [NPINS-1:0]  pin_pullup_en,                // Pad pull-up enable, high on
   output wire [NPINS-1:0]  ext_int_in,                   // Pin levels to interrupt inputs
   output wire              timer_event_input,            // Pin 6 level to the timer
   output wire              converter_external_trigger    // Pin 5 level to the converter
);

   ////////////////////////////////////////////////////////////////////////////
   // Registers and wires

   reg  [NPINS-1:0] port_output_latch_r;
   reg  [NPINS-1:0] port_direction_r;
   reg  [NPINS-1:0] port_pullup_enable_r;

   reg  [31:0]      prdata_r;
   reg  [31:0]      prdata_nxt;
   reg              pready_r;
   reg              pslverr_r;
   reg              pslverr_nxt;

   reg  [NPINS-1:0] pin_out_r;
   reg  [NPINS-1:0] pin_oe_r;
   reg  [NPINS-1:0] pin_pullup_r;
   reg  [NPINS-1:0] ext_int_r;
   reg              timer_event_r;
   reg              conv_trig_r;

   wire [NPINS-1:0] pin_sync;
   wire [15:0]      reg_index;
   wire             sel_latch;
   wire             sel_direction;
   wire             sel_pullup;
   wire             sel_any;
   wire             access_done;
   wire             wr_lane0;
   wire [NPINS-1:0] read_port;
   wire [NPINS-1:0] pullup_want;
   wire             mode_hold;
   wire             mode_standby;

   ////////////////////////////////////////////////////////////////////////////
   // Pin input synchroniser; pins are asynchronous to core_clk

   eio_sync
   #(
      .WIDTH    (NPINS)
   )
   u_sync
   (
      .core_clk (core_clk),
      .rst_b    (rst_b),
      .clk_en   (clk_en),
      .async_in (pin_in),
      .sync_out (pin_sync)
   );

   ////////////////////////////////////////////////////////////////////////////
   // APB address decode

   // Word index; the two low address bits are ignored
   assign reg_index     = paddr[17:2];
   assign sel_latch     = (reg_index == `EIO_IDX_LATCH);
   assign sel_direction = (reg_index == `EIO_IDX_DIRECTION);
   assign sel_pullup    = (reg_index == `EIO_IDX_PULLUP);
   assign sel_any       = sel_latch | sel_direction | sel_pullup;

   // Transfer completes at the edge where the master sees pready high
   assign access_done   = psel & penable & pready_r;

   // Registers sit in byte lane 0; a write without that lane changes nothing
   assign wr_lane0      = access_done & pwrite & pstrb[0] & sel_any;

   ////////////////////////////////////////////////////////////////////////////
   // Port data read mux, per pin

   genvar i;
   generate
      for (i = 0; i < NPINS; i = i + 1)
      begin : g_rd
         // Output pins read the latch, input pins read the synced level
         assign read_port[i] = port_direction_r[i] ? port_output_latch_r[i]
                                                   : pin_sync[i];
      end
   endgenerate

   // Read data selection, unmapped addresses read zero with an error
   always @*
   begin
      prdata_nxt  = 32'h0000_0000;
      pslverr_nxt = 1'b0;
      if (sel_latch)
      begin
         prdata_nxt[NPINS-1:0] = read_port;
      end
      else if (sel_direction)
      begin
         prdata_nxt[7:0] = `EIO_DIRECTION_RD;
      end
      else if (sel_pullup)
      begin
         prdata_nxt[NPINS-1:0] = port_pullup_enable_r;
      end
      else
      begin
         pslverr_nxt = 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // APB handshake: one wait state so the read data can leave a flop

   always @(posedge core_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         pready_r  <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r  <= 32'h0000_0000;
      end
      else if (clk_en)
      begin
         if (psel & penable & ~pready_r)
         begin
            pready_r  <= 1'b1;
            pslverr_r <= pslverr_nxt;
            prdata_r  <= pwrite ? 32'h0000_0000 : prdata_nxt;
         end
         else
         begin
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Software registers

   // All three clear at reset, so every pin starts as an undriven input
   always @(posedge core_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         port_output_latch_r  <= `EIO_LATCH_RST;
         port_direction_r     <= `EIO_DIRECTION_RST;
         port_pullup_enable_r <= `EIO_PULLUP_RST;
      end
      else if (clk_en & wr_lane0)
      begin
         if (sel_latch)
         begin
            port_output_latch_r <= pwdata[NPINS-1:0];
         end
         if (sel_direction)
         begin
            port_direction_r <= pwdata[NPINS-1:0];
         end
         if (sel_pullup)
         begin
            port_pullup_enable_r <= pwdata[NPINS-1:0];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Pad control

   // Pull-up only for input pins with the enable bit set
   assign pullup_want  = ~port_direction_r & port_pullup_enable_r;

   // Sleep, subsleep and watch hold the pads as they were
   assign mode_hold    = (pwr_mode == `EIO_MODE_SLEEP) |
                         (pwr_mode == `EIO_MODE_SUBSLEEP) |
                         (pwr_mode == `EIO_MODE_WATCH);
   assign mode_standby = (pwr_mode == `EIO_MODE_STANDBY);

   // Pad drivers are registered so the pads never see decode glitches
   always @(posedge core_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         pin_out_r    <= 8'h00;
         pin_oe_r     <= 8'h00;
         pin_pullup_r <= 8'h00;
      end
      else if (clk_en)
      begin
         if (mode_standby)
         begin
            // Drivers off; an enabled pull-up still holds the pin high
            pin_oe_r     <= 8'h00;
            pin_pullup_r <= pullup_want;
         end
         else if (!mode_hold)
         begin
            // Active, subactive and unknown codes run normally
            pin_out_r    <= port_output_latch_r;
            pin_oe_r     <= port_direction_r;
            pin_pullup_r <= pullup_want;
         end
         // In hold modes nothing changes
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Feeds to on-chip functions, taken from the pin whatever its direction

   always @(posedge core_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         ext_int_r     <= 8'h00;
         timer_event_r <= 1'b0;
         conv_trig_r   <= 1'b0;
      end
      else if (clk_en)
      begin
         ext_int_r     <= pin_sync;
         timer_event_r <= pin_sync[6];
         conv_trig_r   <= pin_sync[5];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs, all straight from flops

   assign prdata                     = prdata_r;
   assign pready                     = pready_r;
   assign pslverr                    = pslverr_r;
   assign pin_out                    = pin_out_r;
   assign pin_oe                     = pin_oe_r;
   assign pin_pullup_en              = pin_pullup_r;
   assign ext_int_in                 = ext_int_r;
   assign timer_event_input          = timer_event_r;
   assign converter_external_trigger = conv_trig_r;

endmodule

/* logic/eio_sync.v */
// Two-flop synchroniser bank for the asynchronous port pin levels
`timescale 1ns/10ps

module eio_sync
#(
   parameter WIDTH = 8
)
(
   input  wire             core_clk,  // System clock
   input  wire             rst_b,     // Asynchronous reset, active low
   input  wire             clk_en,    // Freezes both stages while low
   input  wire [WIDTH-1:0] async_in,  // Raw pin levels
   output wire [WIDTH-1:0] sync_out   // Levels after two flops
);

   ////////////////////////////////////////////////////////////////////////////
   genvar i;

   // One pair of flops per pin; the first stage feeds only the second
   generate
      for (i = 0; i < WIDTH; i = i + 1)
      begin : g_bit
         reg meta_r;
         reg stable_r;
         always @(posedge core_clk or negedge rst_b)
         begin
            if (!rst_b)
            begin
               meta_r   <= 1'b0;
               stable_r <= 1'b0;
            end
            else if (clk_en)
            begin
               meta_r   <= async_in[i];
               stable_r <= meta_r;
            end
         end
         assign sync_out[i] = stable_r;
      end
   endgenerate

endmodule

/* verif/eio_pad_model.sv */
// Board-side model of the eight port pins
`timescale 1ns/10ps
module eio_pad_model
(
   input  wire       core_clk,       // Clock for the floating pattern
   input  wire [7:0] pin_out,        // Chip pad data
   input  wire [7:0] pin_oe,         // Chip drives when high
   input  wire [7:0] pin_pullup_en,  // Chip pull-up on
   input  wire [7:0] ext_drv,        // Board drive level
   input  wire [7:0] ext_en,         // Board drives when high
   output wire [7:0] lvl             // Resolved pin level
);
   reg [7:0] flt_r = 8'h00;  // Undriven pins wander, so a stale level never reads as valid

   // Chip drive wins, then board drive, then pull-up, else floating
   assign lvl = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_drv) | (~pin_oe & ~ext_en & (pin_pullup_en | flt_r));

   always @(posedge core_clk)
   begin
      flt_r <= ~lvl;
   end
endmodule

/* verif/eio_port_sva.sv */
// Assertion checker for the eight-bit I/O port, bound to its top module
`timescale 1ns/10ps
`include "eio_consts.vh"
module eio_port_sva
#(
   parameter ADDR_W = `EIO_ADDR_W,
   parameter NPINS  = 8
)
(
   input wire              core_clk,                   // Clock
   input wire              rst_b,                      // Reset, active low
   input wire              clk_en,                     // Clock enable
   input wire              psel,                       // APB select
   input wire              penable,                    // APB access
   input wire              pwrite,                     // APB direction
   input wire [ADDR_W-1:0] paddr,                      // APB address
   input wire [31:0]       pwdata,                     // APB write data
   input wire [3:0]        pstrb,                      // APB strobes
   input wire [31:0]       prdata,                     // APB read data
   input wire              pready,                     // APB ready
   input wire              pslverr,                    // APB error
   input wire [2:0]        pwr_mode,                   // Power mode
   input wire [NPINS-1:0]  pin_in,                     // Pad levels
   input wire [NPINS-1:0]  pin_out,                    // Pad data
   input wire [NPINS-1:0]  pin_oe,                     // Pad enable
   input wire [NPINS-1:0]  pin_pullup_en,              // Pull-up enable
   input wire [NPINS-1:0]  ext_int_in,                 // Interrupt feeds
   input wire              timer_event_input,          // Timer feed
   input wire              converter_external_trigger  // Converter feed
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_b);
   wire [15:0] idx = paddr[ADDR_W-1:2];
   wire mapped = idx == `EIO_IDX_LATCH || idx == `EIO_IDX_DIRECTION || idx == `EIO_IDX_PULLUP;

   ////////////////////////////////////////////////////////////////////////////
   // Completed write to one register while the pads are live
   sequence s_wr(ri);
      clk_en && psel && penable && pready && pwrite && pstrb[0] && idx == ri && pwr_mode == `EIO_MODE_ACTIVE;
   endsequence
   sequence s_live;
      clk_en && pwr_mode == `EIO_MODE_ACTIVE;
   endsequence

   a_one_wait: assert property (psel && $rose(penable) |-> !pready ##1 pready) else $error("wait state wrong");
   a_slverr_map: assert property (pready |-> pslverr == !mapped) else $error("slave error wrong");
   a_dir_ones: assert property (pready && !pwrite && idx == `EIO_IDX_DIRECTION |->
      prdata == {24'h0, `EIO_DIRECTION_RD}) else $error("direction read not ones");
   a_dir_to_oe: assert property (s_wr(`EIO_IDX_DIRECTION) ##1 s_live |=>
      pin_oe == $past(pwdata[7:0], 2)) else $error("enable not from direction");
   a_latch_to_pin: assert property (s_wr(`EIO_IDX_LATCH) ##1 s_live |=>
      pin_out == $past(pwdata[7:0], 2)) else $error("pad data not from latch");
   a_pullup_gated: assert property ((pin_pullup_en & pin_oe) == 8'h00) else $error("pull-up on output");
   a_reset_hiz: assert property (disable iff (1'b0) !rst_b |-> pin_oe == 8'h00 && pin_pullup_en == 8'h00)
      else $error("pads active in reset");
   a_hold_sleep: assert property (pwr_mode inside {`EIO_MODE_SLEEP, `EIO_MODE_SUBSLEEP, `EIO_MODE_WATCH} |=>
      $stable(pin_oe) && $stable(pin_out)) else $error("pads moved in sleep");
   a_standby_hiz: assert property (clk_en && pwr_mode == `EIO_MODE_STANDBY |=> pin_oe == 8'h00)
      else $error("pads driven in standby");
   a_int_follows: assert property (clk_en && $changed(pin_in) ##1 (clk_en && $stable(pin_in))[*3] |->
      ext_int_in == pin_in)
      else $error("interrupt feed lags");
   a_timer_pin6: assert property (timer_event_input == ext_int_in[6]) else $error("timer feed wrong");
   a_trig_pin5: assert property (converter_external_trigger == ext_int_in[5]) else $error("trigger wrong");
endmodule

bind eio_port eio_port_sva #(.ADDR_W(ADDR_W), .NPINS(NPINS)) u_sva
(
   .core_clk(core_clk), .rst_b(rst_b), .clk_en(clk_en), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr),
   .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr), .pwr_mode(pwr_mode),
   .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .pin_pullup_en(pin_pullup_en),
   .ext_int_in(ext_int_in), .timer_event_input(timer_event_input),
   .converter_external_trigger(converter_external_trigger)
);

/* verif/tb.sv */
// Register-level testbench for the eight-bit I/O port
`timescale 1ns/10ps
`include "eio_consts.vh"
module tb;
   reg         core_clk, rst_b, clk_en, psel, penable, pwrite;
   reg  [17:0] paddr;
   reg  [31:0] pwdata;
   reg  [3:0]  pstrb;
   reg  [2:0]  pwr_mode;
   reg  [7:0]  ext_drv, ext_en;
   wire [31:0] prdata;
   wire        pready, pslverr, tmr, trg;
   wire [7:0]  pin_out, pin_oe, pu, lvl, irq;
   logic [31:0] rdat;
   logic        err;
   integer      n_fail, checks, i;

   eio_port dut
   (
      .core_clk(core_clk), .rst_b(rst_b), .clk_en(clk_en), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .pwr_mode(pwr_mode), .pin_in(lvl), .pin_out(pin_out), .pin_oe(pin_oe), .pin_pullup_en(pu),
      .ext_int_in(irq), .timer_event_input(tmr), .converter_external_trigger(trg)
   );
   eio_pad_model pads
   (
      .core_clk(core_clk), .pin_out(pin_out), .pin_oe(pin_oe), .pin_pullup_en(pu),
      .ext_drv(ext_drv), .ext_en(ext_en), .lvl(lvl)
   );

   ////////////////////////////////////////////////////////////////////////////
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      checks = checks + 1;
      if (seen !== exp)
      begin
         n_fail = n_fail + 1;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task report_and_stop;
      if (n_fail == 0 && checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   // One APB transfer entered just after an edge; one idle cycle after it avoids double drives
   task apb(input logic w, input logic [15:0] ri, input logic [7:0] d, input logic [3:0] s);
      integer k;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {ri, 2'b00};
      pwdata <= {24'h0, d};
      pstrb <= s;
      @(posedge core_clk);
      penable <= 1'b1;
      k = 0;
      do
      begin
         @(posedge core_clk);
         k = k + 1;
      end
      while (pready !== 1'b1 && k < 20);
      if (k >= 20)
      begin
         n_fail = n_fail + 1;
         report_and_stop();
      end
      rdat = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge core_clk);
   endtask

   task wr(input logic [15:0] ri, input logic [7:0] d);
      apb(1'b1, ri, d, 4'h1);
   endtask

   task rd(input logic [15:0] ri, input logic [31:0] exp);
      apb(1'b0, ri, 8'h00, 4'h0);
      chk(rdat, exp);
   endtask

   // Synchroniser plus output flop need three edges; five leaves margin
   task settle;
      repeat (5) @(posedge core_clk);
   endtask

   ////////////////////////////////////////////////////////////////////////////
   initial
   begin
      core_clk = 1'b0;
      forever #20 core_clk = ~core_clk;
   end

   // Main sequence
   initial
   begin
      n_fail = 0;
      checks = 0;
      {psel, penable, pwrite, paddr, pwdata, pstrb, pwr_mode} = '0;
      clk_en = 1'b1;
      // Non-blocking, so the reset edge reaches processes that are already waiting at time zero
      rst_b <= 1'b0;
      ext_drv = 8'h3C;
      ext_en = 8'hFF;
      repeat (3) @(posedge core_clk);
      chk({24'h0, pin_oe | pu}, 32'h0);
      rst_b <= 1'b1;
      @(posedge core_clk);
      chk({24'h0, pu}, 32'h0);
      rd(`EIO_IDX_LATCH, 32'h3C);
      rd(`EIO_IDX_PULLUP, 32'h0);
      rd(`EIO_IDX_DIRECTION, 32'hFF);
      chk({22'h0, tmr, trg, irq}, 32'h13C);
      wr(`EIO_IDX_PULLUP, 8'hFF);
      wr(`EIO_IDX_DIRECTION, 8'h0F);
      wr(`EIO_IDX_LATCH, 8'hA5);
      ext_en <= 8'hF0;
      settle();
      rd(`EIO_IDX_PULLUP, 32'hFF);
      rd(`EIO_IDX_LATCH, 32'h35);
      chk({8'h0, pin_out, pin_oe, pu}, 32'hA50FF0);
      ext_en <= 8'h00;
      settle();
      rd(`EIO_IDX_LATCH, 32'hF5);
      chk({22'h0, tmr, trg, irq}, 32'h3F5);
      apb(1'b1, `EIO_IDX_LATCH, 8'h00, 4'h0);
      rd(`EIO_IDX_LATCH, 32'hF5);
      apb(1'b0, 16'hFFD0, 8'h00, 4'h0);
      chk({31'h0, err}, 32'h1);
      // Sleep, subsleep and watch hold the pads while registers still move
      for (i = 2; i < 5; i = i + 1)
      begin
         pwr_mode <= i[2:0];
         wr(`EIO_IDX_LATCH, i[7:0]);
         settle();
         chk({24'h0, pin_out}, 32'hA5);
      end
      rd(`EIO_IDX_LATCH, 32'hF4);
      pwr_mode <= `EIO_MODE_STANDBY;
      settle();
      chk({16'h0, pin_oe, pu}, 32'hF0);
      wr(`EIO_IDX_DIRECTION, 8'hFF);
      settle();
      chk({24'h0, pu}, 32'h0);
      pwr_mode <= `EIO_MODE_SUBACTIVE;
      settle();
      chk({16'h0, pin_out, pin_oe}, 32'h04FF);
      // Clock enable low freezes the pads even across a change to standby
      clk_en <= 1'b0;
      pwr_mode <= `EIO_MODE_STANDBY;
      settle();
      chk({24'h0, pin_oe}, 32'hFF);
      clk_en <= 1'b1;
      pwr_mode <= `EIO_MODE_SUBACTIVE;
      @(posedge core_clk);
      rst_b <= 1'b0;
      @(posedge core_clk);
      chk({24'h0, pin_oe}, 32'h0);
      rst_b <= 1'b1;
      settle();
      rd(`EIO_IDX_PULLUP, 32'h0);
      chk({24'h0, pin_out}, 32'h0);
      report_and_stop();
   end
endmodule
